/* design/elid_core.sv */
// Top: decode and execute of the file XOR and the extended literal group.
// Assumes an AXI4-Lite master on aclk and a static extension strap.
//
// Our own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module elid_core
  import elid_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Configuration strap
  input  wire logic        extended_set_enable,
  // AXI4-Lite write address
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic [2:0]  awprot,
  // AXI4-Lite write data
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  // AXI4-Lite write response
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  // AXI4-Lite read address
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  input  wire logic [2:0]  arprot,
  // AXI4-Lite read data
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp
);
  import elid_pkg::*;

  // Bus holding registers
  logic        aw_full_r, w_full_r, bvalid_r, rvalid_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r, rdata_r;
  logic [3:0]  wstrb_r;
  logic [1:0]  bresp_r, rresp_r;
  // Architectural state
  logic [15:0] instr1_r, instr2_r;
  logic [7:0]  work_r, bank_r, pclath_r, pclatu_r, flags_r;
  logic [11:0] fsr_r [0:2];
  logic [20:0] pc_r, tos_r;
  logic [11:0] memaddr_r;
  logic        ext_en_r, strap_done_r, ill_r;
  // Datapath latches
  logic [7:0]  opnd_r, res_r;

  // Merge a bus write into an old value by byte lane
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        m[i*8 +: 8] = nw[i*8 +: 8];
    return m;
  endfunction

  // Strap capture after reset release; never re-sampled while running
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ext_en_r     <= 1'b0;
      strap_done_r <= 1'b0;
    end
    else if (!strap_done_r)
    begin
      ext_en_r     <= extended_set_enable;
      strap_done_r <= 1'b1;
    end
  end

  // Field extraction
  wire [7:0]  f_addr   = instr1_r[7:0];
  wire        dest_bit = instr1_r[9];
  wire        bank_bit = instr1_r[8];
  wire [3:0]  ext_sub  = instr1_r[11:8];
  wire [1:0]  ptr_sel  = instr1_r[7:6];
  wire [11:0] lit6     = {6'h00, instr1_r[5:0]};
  wire [11:0] pointer_two     = fsr_r[2];

  // Decode; extended opcodes only exist with the strap set
  wire is_xor    = (instr1_r[15:10] == XOR_PFX);
  wire ext_grp   = ext_en_r && (instr1_r[15:12] == EXT_PFX);
  wire is_ret    = (ptr_sel == PTR_RET_SEL);
  wire second_ok = (instr2_r[15:12] == SECOND_PFX);
  wire is_call_via_working_register  = ext_en_r && (instr1_r == CALL_VIA_WORKING_REGISTER_WORD);
  wire is_add    = ext_grp && (ext_sub == SUB_ADD_LITERAL_TO_POINTER);
  wire is_sub    = ext_grp && (ext_sub == SUB_SUBTRACT_LITERAL_FROM_POINTER);
  wire is_push   = ext_grp && (ext_sub == SUB_PUSH_LITERAL);
  wire is_movs   = ext_grp && (ext_sub == SUB_MOVS) && second_ok;

  elid_op_t op;
  assign op = is_xor   ? OP_XOR :
              is_add   ? (is_ret ? OP_ADDRET : OP_ADD_LITERAL_TO_POINTER) :
              is_sub   ? (is_ret ? OP_SUBRET : OP_SUBTRACT_LITERAL_FROM_POINTER) :
              is_push  ? OP_PUSH_LITERAL :
              is_movs  ? (instr1_r[7] ? OP_MOVE_INDEXED_TO_INDEXED : OP_MOVE_INDEXED_TO_FILE) :
              is_call_via_working_register ? OP_CALL_VIA_WORKING_REGISTER : OP_ILL;

  wire two_cycle = (op == OP_ADDRET) || (op == OP_SUBRET) || (op == OP_CALL_VIA_WORKING_REGISTER) ||
                   (op == OP_MOVE_INDEXED_TO_FILE) || (op == OP_MOVE_INDEXED_TO_INDEXED);

  // Address formation for the file XOR
  wire        idx_mode = ext_en_r && !bank_bit && (f_addr <= ACCESS_LIM);
  wire [11:0] acc_addr = (f_addr <= ACCESS_LIM) ? {4'h0, f_addr} : {ACCESS_HI, f_addr};
  wire [11:0] xor_ea   = bank_bit ? {bank_r[3:0], f_addr} :
                         idx_mode ? pointer_two + {4'h0, f_addr} : acc_addr;

  // Address formation for the two-word moves
  wire [11:0] movs_src = pointer_two + {5'h00, instr1_r[6:0]};
  wire [11:0] movs_dst = instr1_r[7] ? pointer_two + {5'h00, instr2_r[6:0]} :
                         instr2_r[11:0];
  wire        is_move  = (op == OP_MOVE_INDEXED_TO_FILE) || (op == OP_MOVE_INDEXED_TO_INDEXED);

  // Sequencer
  logic [1:0] q;
  logic       cyc, busy, last;
  wire        wr_fire = aw_full_r && w_full_r && !bvalid_r;
  wire [31:0] wr_data = merge(32'h00000000, wdata_r, wstrb_r);
  wire        start   = wr_fire && (awaddr_r == OFS_CTRL) && wr_data[CTRL_GO_BIT] &&
                        !busy && strap_done_r;

  elid_qseq u_qseq (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .start     (start),
    .two_cycle (two_cycle),
    .q         (q),
    .cyc       (cyc),
    .busy      (busy),
    .last      (last)
  );

  // Phase strobes of the first and second instruction cycle
  wire q2_c0 = busy && !cyc && (q == 2'h1);
  wire q3_c0 = busy && !cyc && (q == 2'h2);
  wire q4_c0 = busy && !cyc && (q == Q_LAST);
  wire q4_c1 = busy && cyc && (q == Q_LAST);

  // Data space; execution owns the write port while busy
  logic [7:0] rd_exec, rd_sw;
  wire        ex_we_xor  = q4_c0 && (op == OP_XOR) && dest_bit;
  wire        ex_we_push = q4_c0 && (op == OP_PUSH_LITERAL);
  wire        ex_we_move = q4_c1 && is_move;
  wire        ex_we      = ex_we_xor || ex_we_push || ex_we_move;
  wire        sw_mem_we  = wr_fire && !busy && (awaddr_r == OFS_MEMDATA) && wstrb_r[0];
  wire [11:0] ex_waddr   = ex_we_push ? pointer_two : ex_we_move ? movs_dst : xor_ea;
  wire [7:0]  ex_wdata   = ex_we_push ? instr1_r[7:0] : ex_we_move ? opnd_r : res_r;
  wire [11:0] ex_raddr   = is_move ? movs_src : xor_ea;

  elid_dmem u_dmem (
    .aclk    (aclk),
    .we      (ex_we || sw_mem_we),
    .waddr   (ex_we ? ex_waddr : memaddr_r),
    .wdata   (ex_we ? ex_wdata : wr_data[7:0]),
    .raddr_a (ex_raddr),
    .rdata_a (rd_exec),
    .raddr_b (memaddr_r),
    .rdata_b (rd_sw)
  );

  // Operand read at Q2 (XOR) or Q4 (move source), XOR processed at Q3
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      opnd_r <= RST_BYTE;
      res_r  <= RST_BYTE;
    end
    else
    begin
      if ((q2_c0 && (op == OP_XOR)) || (q4_c0 && is_move))
        opnd_r <= rd_exec;
      if (q3_c0)
        res_r <= work_r ^ opnd_r;
    end
  end

  // Pointer arithmetic for the literal group
  wire [1:0]  fsel     = is_ret ? 2'h2 : ptr_sel;
  wire        sub_op   = (op == OP_SUBTRACT_LITERAL_FROM_POINTER) || (op == OP_SUBRET);
  wire [11:0] ptr_old  = fsr_r[fsel];
  wire [11:0] ptr_new  = sub_op ? ptr_old - lit6 : ptr_old + lit6;
  wire        ptr_op   = (op == OP_ADD_LITERAL_TO_POINTER) || (op == OP_SUBTRACT_LITERAL_FROM_POINTER) ||
                         (op == OP_ADDRET) || (op == OP_SUBRET);
  wire        ptr_wr   = q4_c0 && ptr_op && (fsel != PTR_RET_SEL);
  wire        sw_we    = wr_fire && !busy;

  // Software or execution writes to the pointers
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_fsr
      wire [7:0]  ofs   = OFS_FSR0 + 8'(4 * g);
      wire [31:0] merged = merge({20'h00000, fsr_r[g]}, wdata_r, wstrb_r);
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          fsr_r[g] <= RST_PTR;
        else if (ptr_wr && (fsel == 2'(g)))
          fsr_r[g] <= ptr_new;
        else if (ex_we_push && (g == 2))
          fsr_r[g] <= pointer_two - 12'h001;
        else if (sw_we && (awaddr_r == ofs))
          fsr_r[g] <= merged[11:0];
      end
    end
  endgenerate

  // Program flow: return, call through W, or fall through
  wire        ret_op  = (op == OP_ADDRET) || (op == OP_SUBRET);
  wire [20:0] pc_fall = is_move ? pc_r + PC_STEP2 : pc_r + PC_STEP1;
  wire [20:0] pc_call = {pclatu_r[4:0], pclath_r, work_r};
  wire [31:0] m_pc    = merge({11'h000, pc_r}, wdata_r, wstrb_r);
  wire [31:0] m_tos   = merge({11'h000, tos_r}, wdata_r, wstrb_r);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pc_r  <= RST_PC;
      tos_r <= RST_PC;
    end
    else if (q4_c0 && ret_op)
      pc_r <= tos_r;
    else if (q4_c0 && (op == OP_CALL_VIA_WORKING_REGISTER))
    begin
      tos_r <= pc_r + PC_STEP1;
      pc_r  <= pc_call;
    end
    else if (last && !ret_op && (op != OP_CALL_VIA_WORKING_REGISTER))
      pc_r <= pc_fall;
    else if (sw_we && (awaddr_r == OFS_PC))
      pc_r <= m_pc[20:0];
    else if (sw_we && (awaddr_r == OFS_TOS))
      tos_r <= m_tos[20:0];
  end

  // Working register and status flags; written only by the XOR or by software
  wire xor_wb = q4_c0 && (op == OP_XOR);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      work_r  <= RST_BYTE;
      flags_r <= RST_BYTE;
    end
    else if (xor_wb)
    begin
      if (!dest_bit)
        work_r <= res_r;
      flags_r[FLAG_N_BIT] <= res_r[7];
      flags_r[FLAG_Z_BIT] <= (res_r == RST_BYTE);
    end
    else if (sw_we && wstrb_r[0])
    begin
      if (awaddr_r == OFS_WORK)
        work_r <= wdata_r[7:0];
      if (awaddr_r == OFS_FLAGS)
        flags_r <= wdata_r[7:0];
    end
  end

  // Instruction words, bank, latches and memory window: software only, idle only
  wire [31:0] m_i1 = merge({16'h0000, instr1_r}, wdata_r, wstrb_r);
  wire [31:0] m_i2 = merge({16'h0000, instr2_r}, wdata_r, wstrb_r);
  wire [31:0] m_ma = merge({20'h00000, memaddr_r}, wdata_r, wstrb_r);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      instr1_r  <= 16'h0000;
      instr2_r  <= 16'h0000;
      bank_r    <= RST_BYTE;
      pclath_r  <= RST_BYTE;
      pclatu_r  <= RST_BYTE;
      memaddr_r <= RST_PTR;
    end
    else if (sw_we)
    begin
      if (awaddr_r == OFS_INSTR1)
        instr1_r <= m_i1[15:0];
      if (awaddr_r == OFS_INSTR2)
        instr2_r <= m_i2[15:0];
      if ((awaddr_r == OFS_BANK) && wstrb_r[0])
        bank_r <= wdata_r[7:0];
      if ((awaddr_r == OFS_PCLATH) && wstrb_r[0])
        pclath_r <= wdata_r[7:0];
      if ((awaddr_r == OFS_PCLATU) && wstrb_r[0])
        pclatu_r <= wdata_r[7:0];
      if (awaddr_r == OFS_MEMADDR)
        memaddr_r <= m_ma[11:0];
    end
  end

  // Unrecognised word: recorded at go, replaced by the next go
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ill_r <= 1'b0;
    else if (start)
      ill_r <= (op == OP_ILL);
  end

  // Address map hits
  wire wr_hit = (awaddr_r[1:0] == 2'h0) && (awaddr_r <= OFS_MEMDATA);
  wire rd_hit = (araddr[1:0] == 2'h0) && (araddr <= OFS_MEMDATA);

  // Read data selection
  logic [31:0] rd_val;
  always_comb
  begin
    rd_val = 32'h00000000;
    case (araddr)
      OFS_STAT:
      begin
        rd_val[STAT_BUSY] = busy;
        rd_val[STAT_EXT]  = ext_en_r;
        rd_val[STAT_ILL]  = ill_r;
        rd_val[STAT_CYC]  = cyc;
      end
      OFS_INSTR1:  rd_val = {16'h0000, instr1_r};
      OFS_INSTR2:  rd_val = {16'h0000, instr2_r};
      OFS_WORK:    rd_val = {24'h000000, work_r};
      OFS_BANK:    rd_val = {24'h000000, bank_r};
      OFS_FSR0:    rd_val = {20'h00000, fsr_r[0]};
      OFS_FSR1:    rd_val = {20'h00000, fsr_r[1]};
      OFS_POINTER_TWO:    rd_val = {20'h00000, fsr_r[2]};
      OFS_FLAGS:   rd_val = {24'h000000, flags_r};
      OFS_PC:      rd_val = {11'h000, pc_r};
      OFS_TOS:     rd_val = {11'h000, tos_r};
      OFS_PCLATH:  rd_val = {24'h000000, pclath_r};
      OFS_PCLATU:  rd_val = {24'h000000, pclatu_r};
      OFS_MEMADDR: rd_val = {20'h00000, memaddr_r};
      OFS_MEMDATA: rd_val = {24'h000000, rd_sw};
      default:     rd_val = 32'h00000000;
    endcase
  end

  // Write channel: address and data taken in either order, answered once both held
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h00000000;
      wstrb_r   <= 4'h0;
      bresp_r   <= RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_full_r <= 1'b1;
        awaddr_r  <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_full_r <= 1'b1;
        wdata_r  <= wdata;
        wstrb_r  <= wstrb;
      end
      if (wr_fire)
      begin
        aw_full_r <= 1'b0;
        w_full_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_r && bready)
        bvalid_r <= 1'b0;
    end
  end

  // Read channel: one outstanding read, data registered
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h00000000;
      rresp_r  <= RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_val;
      rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_r && rready)
      rvalid_r <= 1'b0;
  end

  // Handshake outputs; holding registers stall the master while full
  assign awready = !aw_full_r;
  assign wready  = !w_full_r;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;
  assign arready = !rvalid_r;
  assign rvalid  = rvalid_r;
  assign rdata   = rdata_r;
  assign rresp   = rresp_r;
endmodule

/* design/elid_pkg.sv */
// Constants shared by the extended literal instruction decode block.
// Assumes a 32-bit AXI4-Lite register port and a 125 MHz core clock.
package elid_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STAT    = 8'h04;
  localparam logic [7:0] OFS_INSTR1  = 8'h08;
  localparam logic [7:0] OFS_INSTR2  = 8'h0C;
  localparam logic [7:0] OFS_WORK    = 8'h10;
  localparam logic [7:0] OFS_BANK    = 8'h14;
  localparam logic [7:0] OFS_FSR0    = 8'h18;
  localparam logic [7:0] OFS_FSR1    = 8'h1C;
  localparam logic [7:0] OFS_POINTER_TWO    = 8'h20;
  localparam logic [7:0] OFS_FLAGS   = 8'h24;
  localparam logic [7:0] OFS_PC      = 8'h28;
  localparam logic [7:0] OFS_TOS     = 8'h2C;
  localparam logic [7:0] OFS_PCLATH  = 8'h30;
  localparam logic [7:0] OFS_PCLATU  = 8'h34;
  localparam logic [7:0] OFS_MEMADDR = 8'h38;
  localparam logic [7:0] OFS_MEMDATA = 8'h3C;

  // Field positions
  localparam int CTRL_GO_BIT  = 0;
  localparam int FLAG_Z_BIT   = 2;
  localparam int FLAG_N_BIT   = 4;
  localparam int STAT_BUSY    = 0;
  localparam int STAT_EXT     = 1;
  localparam int STAT_ILL     = 2;
  localparam int STAT_CYC     = 3;

  // Opcode patterns
  localparam logic [5:0]  XOR_PFX     = 6'h06;
  localparam logic [3:0]  EXT_PFX     = 4'hE;
  localparam logic [3:0]  SUB_ADD_LITERAL_TO_POINTER  = 4'h8;
  localparam logic [3:0]  SUB_SUBTRACT_LITERAL_FROM_POINTER  = 4'h9;
  localparam logic [3:0]  SUB_PUSH_LITERAL   = 4'hA;
  localparam logic [3:0]  SUB_MOVS    = 4'hB;
  localparam logic [3:0]  SECOND_PFX  = 4'hF;
  localparam logic [15:0] CALL_VIA_WORKING_REGISTER_WORD  = 16'h0014;
  localparam logic [1:0]  PTR_RET_SEL = 2'h3;
  localparam logic [7:0]  ACCESS_LIM  = 8'h5F;
  localparam logic [3:0]  ACCESS_HI   = 4'hF;

  // Reset values and steps
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [11:0] RST_PTR     = 12'h000;
  localparam logic [20:0] RST_PC      = 21'h000000;
  localparam logic [20:0] PC_STEP1    = 21'h000002;
  localparam logic [20:0] PC_STEP2    = 21'h000004;
  localparam logic [1:0]  Q_LAST      = 2'h3;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum {
    OP_ILL, OP_XOR, OP_ADD_LITERAL_TO_POINTER, OP_SUBTRACT_LITERAL_FROM_POINTER, OP_ADDRET, OP_SUBRET,
    OP_CALL_VIA_WORKING_REGISTER, OP_MOVE_INDEXED_TO_FILE, OP_MOVE_INDEXED_TO_INDEXED, OP_PUSH_LITERAL
  } elid_op_t;

endpackage

/* design/elid_qseq.sv */
// Four-phase instruction cycle sequencer, one or two cycles per instruction.
// Assumes start is a one-cycle pulse given only while idle.
`timescale 1ns/1ps
module elid_qseq
  import elid_pkg::*;
(
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Control
  input  wire logic       start,
  input  wire logic       two_cycle,
  // Progress
  output logic [1:0]      q,
  output logic            cyc,
  output logic            busy,
  output logic            last
);
  import elid_pkg::*;

  logic [1:0] q_r;
  logic       cyc_r;
  logic       busy_r;
  logic       two_r;

  // Phase and cycle counting; Q1..Q4 map to q 0..3
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q_r    <= 2'h0;
      cyc_r  <= 1'b0;
      busy_r <= 1'b0;
      two_r  <= 1'b0;
    end
    else if (start)
    begin
      q_r    <= 2'h0;
      cyc_r  <= 1'b0;
      busy_r <= 1'b1;
      two_r  <= two_cycle;
    end
    else if (busy_r)
    begin
      q_r <= q_r + 2'h1;
      if (q_r == Q_LAST)
      begin
        cyc_r  <= ~cyc_r;
        busy_r <= (cyc_r != two_r);
      end
    end
  end

  assign q    = q_r;
  assign cyc  = cyc_r;
  assign busy = busy_r;
  assign last = busy_r && (q_r == Q_LAST) && (cyc_r == two_r);
endmodule

/* design/elid_dmem.sv */
// Byte-wide 4096-entry data space, one write port and two read ports.
// Assumes the caller muxes the single write port between its users.
`timescale 1ns/1ps
module elid_dmem
(
  // Clock
  input  wire logic        aclk,
  // Write port
  input  wire logic        we,
  input  wire logic [11:0] waddr,
  input  wire logic [7:0]  wdata,
  // Read ports
  input  wire logic [11:0] raddr_a,
  output logic [7:0]       rdata_a,
  input  wire logic [11:0] raddr_b,
  output logic [7:0]       rdata_b
);
  logic [7:0] mem [0:4095];

  // Contents are undefined after power-up, as in real file space
  always_ff @(posedge aclk)
  begin
    if (we)
      mem[waddr] <= wdata;
  end

  assign rdata_a = mem[raddr_a];
  assign rdata_b = mem[raddr_b];
endmodule

/* bench/elid_core_asserts.sv */
// Checker for the register port of the decode block.
// Assumes it is bound onto elid_core and the strap only moves during reset.
`timescale 1ns/1ps
module elid_asserts
  import elid_pkg::*;
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Strap
  input wire logic        extended_set_enable,
  // Read side
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [7:0]  araddr,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  // Write response
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Read address accepted
  sequence s_rd_take;
    arvalid && arready;
  endsequence

  // Read answers follow the handshake; read and write answers stand until taken
  a_rd_answer: assert property (s_rd_take |=> rvalid)
    else $error("read data did not follow address");
  a_rd_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data dropped or changed early");
  a_wr_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped or changed early");
  a_ar_block: assert property (rvalid |-> !arready)
    else $error("second read accepted while answer pending");
  // Strap shows in status; it is static so no race with capture
  a_strap_stat: assert property (
    s_rd_take ##0 (araddr == OFS_STAT) |=> rdata[STAT_EXT] == extended_set_enable)
    else $error("status does not show extension state");
  a_bad_addr: assert property (
    s_rd_take ##0 (araddr > OFS_MEMDATA || araddr[1:0] != 2'h0) |=> rresp == RESP_SLVERR)
    else $error("unmapped read not refused");
  a_good_addr: assert property (
    s_rd_take ##0 (araddr <= OFS_MEMDATA && araddr[1:0] == 2'h0) |=> rresp == RESP_OKAY)
    else $error("mapped read refused");
  a_ctrl_zero: assert property (s_rd_take ##0 (araddr == OFS_CTRL) |=> rdata == 32'h0)
    else $error("control register reads nonzero");
endmodule

bind elid_core elid_asserts i_chk (.aclk(aclk), .aresetn(aresetn),
  .extended_set_enable(extended_set_enable), .arvalid(arvalid), .arready(arready),
  .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
  .bvalid(bvalid), .bready(bready), .bresp(bresp));

/* bench/test_extended_literal_instruction_decode.sv */
// Testbench: runs each instruction kind through the register port.
// Assumes the register map and go/busy handshake of elid_core.
`timescale 1ns/1ps
module test_extended_literal_instruction_decode;
  import elid_pkg::*;
  typedef struct {logic [31:0] e; logic [31:0] m; logic [1:0] r;} elid_exp_t;
  logic aclk, aresetn, ext_en, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr, wv, fv, rs;
  logic [2:0] awprot, arprot;
  logic [3:0] wstrb;
  logic [31:0] wdata, rdata, rdv;
  logic [1:0] bresp, rresp;
  logic [5:0] k;
  elid_exp_t rq[$];
  elid_exp_t ex;
  logic [1:0] bq[$];
  int miscompares, samples_checked, i;

  elid_core i_dut (.aclk(aclk), .aresetn(aresetn), .extended_set_enable(ext_en),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(awprot),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(arprot),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

  // 125 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic check(input logic [33:0] s, input logic [33:0] x);
    samples_checked++;
    if (s !== x)
    begin
      miscompares++;
      $display("[FAIL] %0t: seen %h expected %h", $time, s, x);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Results are compared in arrival order against the driver's notes
  always @(posedge aclk)
  begin
    if (rvalid === 1'b1 && rready)
    begin
      ex = rq.pop_front();
      check({rresp, rdata & ex.m}, {ex.r, ex.e});
    end
    if (bvalid === 1'b1 && bready)
      check({bresp, 32'h0}, {bq.pop_front(), 32'h0});
  end

  task automatic reset;
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = RESP_OKAY);
    bq.push_back(r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    while ((awvalid && !awready) || (wvalid && !wready));
    while (!bvalid) @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hFFFFFFFF, input logic [1:0] r = RESP_OKAY);
    rq.push_back('{e, m, r});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    rdv = rdata;
  endtask

  task automatic mw(input logic [11:0] a, input logic [7:0] d);
    wr(OFS_MEMADDR, {20'h0, a});
    wr(OFS_MEMDATA, {24'h0, d});
  endtask

  task automatic mr(input logic [11:0] a, input logic [7:0] d);
    wr(OFS_MEMADDR, {20'h0, a});
    rd(OFS_MEMDATA, {24'h0, d});
  endtask

  // Poll with a bound so a stuck busy flag is reported, not hung on
  task automatic go;
    int n;
    n = 0;
    wr(OFS_CTRL, 32'h1);
    do
    begin
      rd(OFS_STAT, 32'h0, 32'h0);
      n++;
    end
    while (rdv[STAT_BUSY] && n < 20);
    if (rdv[STAT_BUSY]) check(34'h1, 34'h0);
  endtask

  function automatic logic [31:0] fl(input logic [7:0] r);
    return {27'h0, r[7], 1'b0, r == 8'h0, 2'h0};
  endfunction

  initial
  begin
    #200000;
    miscompares++;
    conclude();
  end

  initial
  begin
    {awvalid, wvalid, arvalid, bready, rready} = 5'h0;
    {awaddr, araddr, awprot, arprot, wdata} = '0;
    wstrb = 4'hF;
    ext_en = 1'b1;
    aresetn = 1'b0;
    void'($urandom(32'hB4CF));
    reset();
    wv = 8'($urandom);
    fv = 8'($urandom);
    rs = wv ^ fv;
    rd(OFS_STAT, 32'h2, 32'h2);
    // Banked XOR into the working register
    wr(OFS_BANK, 32'h2);
    wr(OFS_WORK, {24'h0, wv});
    mw(12'h2AB, fv);
    wr(OFS_INSTR1, 32'h19AB);
    go();
    rd(OFS_WORK, {24'h0, rs});
    rd(OFS_FLAGS, fl(rs));
    mr(12'h2AB, fv);
    rd(OFS_PC, 32'h2);
    // Indexed XOR back into the file
    wr(OFS_WORK, {24'h0, wv});
    wr(OFS_POINTER_TWO, 32'h100);
    mw(12'h110, fv);
    wr(OFS_INSTR1, 32'h1A10);
    go();
    mr(12'h110, rs);
    rd(OFS_WORK, {24'h0, wv});
    // Upper access bank, equal operands give zero
    mw(12'hF60, wv);
    wr(OFS_INSTR1, 32'h1860);
    go();
    rd(OFS_WORK, 32'h0);
    rd(OFS_FLAGS, 32'h4);
    // Add then subtract on each plain selector
    for (i = 0; i < 3; i++)
    begin
      k = 6'($urandom);
      wr(OFS_FSR0 + 8'(4 * i), 32'h3FF);
      wr(OFS_INSTR1, {16'h0, 8'hE8, 2'(i), k});
      go();
      rd(OFS_FSR0 + 8'(4 * i), 32'h3FF + {26'h0, k});
      wr(OFS_INSTR1, {16'h0, 8'hE9, 2'(i), k});
      go();
      rd(OFS_FSR0 + 8'(4 * i), 32'h3FF);
    end
    rd(OFS_FLAGS, 32'h4);
    // Pointer two with return
    wr(OFS_POINTER_TWO, 32'h3FF);
    wr(OFS_TOS, 32'h1234);
    wr(OFS_INSTR1, 32'hE8E3);
    go();
    rd(OFS_POINTER_TWO, 32'h422);
    rd(OFS_PC, 32'h1234);
    wr(OFS_INSTR1, 32'hE9C3);
    go();
    rd(OFS_POINTER_TWO, 32'h41F);
    // Call through the working register
    wr(OFS_WORK, 32'h6);
    wr(OFS_PCLATH, 32'h10);
    wr(OFS_PC, 32'h100);
    wr(OFS_INSTR1, 32'h14);
    go();
    rd(OFS_PC, 32'h1006);
    rd(OFS_TOS, 32'h102);
    rd(OFS_FLAGS, 32'h4);
    // Literal push
    wr(OFS_POINTER_TWO, 32'h200);
    wr(OFS_INSTR1, 32'hEA55);
    go();
    mr(12'h200, 8'h55);
    rd(OFS_POINTER_TWO, 32'h1FF);
    // Two-word moves, file then indexed destination
    wr(OFS_POINTER_TWO, 32'h80);
    mw(12'h85, fv);
    wr(OFS_PC, 32'h0);
    wr(OFS_INSTR1, 32'hEB05);
    wr(OFS_INSTR2, 32'hF123);
    go();
    mr(12'h123, fv);
    rd(OFS_PC, 32'h4);
    wr(OFS_INSTR1, 32'hEB85);
    wr(OFS_INSTR2, 32'hF007);
    go();
    mr(12'h87, fv);
    // Unmapped places are refused; the control register reads as zero
    rd(8'h40, 32'h0, 32'h0, RESP_SLVERR);
    rd(OFS_CTRL, 32'h0);
    wr(8'h42, 32'h0, RESP_SLVERR);
    // Strap off: extended group is unrecognised and the XOR is not indexed
    ext_en <= 1'b0;
    reset();
    rd(OFS_STAT, 32'h0, 32'h2);
    wr(OFS_INSTR1, 32'hE823);
    go();
    rd(OFS_FSR0, 32'h0);
    rd(OFS_STAT, 32'h4, 32'h4);
    wr(OFS_WORK, {24'h0, wv});
    wr(OFS_POINTER_TWO, 32'h100);
    mw(12'h010, fv);
    wr(OFS_INSTR1, 32'h1A10);
    go();
    mr(12'h010, rs);
    conclude();
  end
endmodule
